/* logic/wdei_line_mon.v */
// one monitored line: direction select, edge detect and blanking timer
`timescale 1ns/1ns
`include "wdei_regs.vh"
module wdei_line_mon #(
  parameter [`WDEI_BW-1:0] BLANK_LONG  = 22'h30D400,
  parameter [`WDEI_BW-1:0] BLANK_SHORT = 22'h007D00
) (
  // clock and reset
  input  wire clk,
  input  wire rst_b,
  // control
  input  wire rise_sel,
  input  wire blank_long,
  // line and event
  input  wire line_in,
  output reg  hit
);
  reg                 line_q;
  reg                 primed;
  reg [`WDEI_BW-1:0]  blank_cnt;
  wire edge_ok = rise_sel ? (line_in & ~line_q) : (~line_in & line_q);
  // first cycle after reset only loads the line, so a line already high is no edge
  wire fire    = primed && edge_ok && (blank_cnt == {`WDEI_BW{1'b0}});

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_q    <= 1'b0;
      primed    <= 1'b0;
      blank_cnt <= {`WDEI_BW{1'b0}};
      hit       <= 1'b0;
    end else begin
      line_q <= line_in;
      primed <= 1'b1;
      hit    <= fire;
      if (fire)
        blank_cnt <= blank_long ? BLANK_LONG : BLANK_SHORT;
      else if (blank_cnt != {`WDEI_BW{1'b0}})
        blank_cnt <= blank_cnt - 1'b1;
    end
  end
endmodule // wdei_line_mon

/* logic/wdei_regs.vh */
// constants for the watchdog and edge interrupt unit
`ifndef WDEI_REGS_VH
`define WDEI_REGS_VH
`define WDEI_CLK_MHZ        100
`define WDEI_WIN_LO_MS      900
`define WDEI_WIN_HI_MS      1100
`define WDEI_PERIOD_MS      1000
`define WDEI_OPEN_MS        100
`define WDEI_BLANK_LONG_US  32000
`define WDEI_BLANK_SHORT_US 320
`define WDEI_MS_CYC(ms)     ((ms) * 1000 * `WDEI_CLK_MHZ)
`define WDEI_US_CYC(us)     ((us) * `WDEI_CLK_MHZ)
`define WDEI_CW             28
`define WDEI_BW             22
`define WDEI_LINES          8
`define WDEI_CHW            8
`define WDEI_MODE_WINDOW    1'b0
`define WDEI_MODE_PERIODIC  1'b1
`endif

/* logic/wdei_unit.v */
// watchdog and edge interrupt unit top
// Contract
// - alarm when output transfer misses its time; periodic mode alarms on a transfer outside the window but not on a missing one
// - window mode: transfer only 900-1100 ms apart
// - periodic mode: request every one second
// - periodic mode: transfer within 100 ms
// - alarm opens relay contacts, else closed
// - four line pairs raise request on edge
// - software sets and device applies direction
// - blank further edges after a request
// - blanking 32 ms or 320 us by strap
// - even channel watchdog, odd channel interrupts
// - single function takes any channel
// - one shared request line for both
`timescale 1ns/1ns
`include "wdei_regs.vh"
module wdei_unit #(
  parameter [`WDEI_CW-1:0] WIN_LO  = `WDEI_MS_CYC(`WDEI_WIN_LO_MS),
  parameter [`WDEI_CW-1:0] WIN_HI  = `WDEI_MS_CYC(`WDEI_WIN_HI_MS),
  parameter [`WDEI_CW-1:0] PERIOD  = `WDEI_MS_CYC(`WDEI_PERIOD_MS),
  parameter [`WDEI_CW-1:0] OPEN_W  = `WDEI_MS_CYC(`WDEI_OPEN_MS),
  parameter [`WDEI_BW-1:0] BLANK_L = `WDEI_US_CYC(`WDEI_BLANK_LONG_US),
  parameter [`WDEI_BW-1:0] BLANK_S = `WDEI_US_CYC(`WDEI_BLANK_SHORT_US)
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst_b,
  // channel configuration straps
  input  wire [`WDEI_CHW-1:0] base_chan,
  input  wire                 wd_fitted,
  input  wire                 ei_fitted,
  input  wire                 blank_long,
  // peripheral bus transfer
  input  wire                 out_strobe,
  input  wire [`WDEI_CHW-1:0] out_chan,
  input  wire [`WDEI_LINES-1:0] out_data,
  input  wire                 ack_req,
  // watchdog control
  input  wire                 wd_mode,
  input  wire                 alarm_clear,
  // external lines
  input  wire [`WDEI_LINES-1:0] line_in,
  // outputs
  output reg                  request,
  output reg                  wd_req_pend,
  output reg  [`WDEI_LINES-1:0] ei_pend,
  output reg  [`WDEI_LINES-1:0] edge_dir,
  output reg                  alarm,
  output reg                  relay_closed
);
  reg  [`WDEI_CW-1:0]    wd_cnt;
  reg                    armed;
  // next values of the state above and of the output flops
  reg  [`WDEI_CW-1:0]    next_wd_cnt;
  reg                    next_armed;
  reg                    next_alarm;
  reg                    next_wd_req_pend;
  reg  [`WDEI_LINES-1:0] next_ei_pend;
  reg  [`WDEI_LINES-1:0] next_edge_dir;
  wire [`WDEI_LINES-1:0] hit;
  wire [`WDEI_LINES-1:0] ei_hit;

  // channel decode
  wire [`WDEI_CHW-1:0]   even_chan = {base_chan[`WDEI_CHW-1:1], 1'b0};
  wire [`WDEI_CHW-1:0]   odd_chan  = {base_chan[`WDEI_CHW-1:1], 1'b1};
  // both fitted: even number is watchdog, odd is interrupts; else any number
  wire both   = wd_fitted & ei_fitted;
  wire wd_sel = wd_fitted &&
                (both ? (out_chan == even_chan) : (out_chan == base_chan));
  wire ei_sel = ei_fitted &&
                (both ? (out_chan == odd_chan) : (out_chan == base_chan));
  wire kick   = out_strobe & wd_sel;
  wire dir_wr = out_strobe & ei_sel;

  // window mode: early transfer, or none by the upper bound
  // limitation: past the upper bound the alarm re-latches every cycle
  // until a transfer restarts the timing
  wire early   = kick && (wd_cnt < WIN_LO);
  wire late    = (wd_cnt >= WIN_HI);
  wire win_bad = armed && (early || late);

  // periodic mode: the count restarts each period and a tick opens the window
  // a count left high by a mode change ticks at once instead of wrapping
  wire tick     = (wd_cnt >= PERIOD - 1'b1);
  wire in_open  = armed && (wd_cnt < OPEN_W);
  wire per_bad  = kick && !in_open;
  wire tick_req = wd_fitted && (wd_mode == `WDEI_MODE_PERIODIC) && tick;

  // any violation of the selected mode
  wire viol    = wd_fitted && ((wd_mode == `WDEI_MODE_WINDOW) ? win_bad : per_bad);

  // only a fitted interrupt section may raise line requests
  assign ei_hit = hit & {`WDEI_LINES{ei_fitted}};

  // one monitor per line: direction, edge detect and blanking
  genvar i;
  generate
    for (i = 0; i < `WDEI_LINES; i = i + 1) begin : g_line
      wdei_line_mon #(.BLANK_LONG(BLANK_L), .BLANK_SHORT(BLANK_S)) u_mon (
        .clk        (clk),
        .rst_b      (rst_b),
        .rise_sel   (edge_dir[i]),
        .blank_long (blank_long),
        .line_in    (line_in[i]),
        .hit        (hit[i])
      );
    end
  endgenerate

  // watchdog counter and arming
  always @* begin
    next_wd_cnt = wd_cnt;
    next_armed  = armed;
    if (wd_mode == `WDEI_MODE_WINDOW) begin
      if (kick) begin
        next_wd_cnt = {`WDEI_CW{1'b0}};
        next_armed  = 1'b1;
      end else if (!late) begin
        next_wd_cnt = wd_cnt + 1'b1;
      end
    end else begin
      // one transfer per window; a tick in the same cycle still opens the next
      if (kick) begin
        next_armed = 1'b0;
      end
      if (tick) begin
        next_wd_cnt = {`WDEI_CW{1'b0}};
        next_armed  = 1'b1;
      end else begin
        next_wd_cnt = wd_cnt + 1'b1;
      end
    end
  end

  // alarm latches on a violation; a violation wins over a clear
  always @* begin
    next_alarm = alarm;
    if (viol) begin
      next_alarm = 1'b1;
    end else if (alarm_clear) begin
      next_alarm = 1'b0;
    end
  end

  // periodic tick request; a tick wins over an acknowledge
  always @* begin
    next_wd_req_pend = wd_req_pend;
    if (tick_req) begin
      next_wd_req_pend = 1'b1;
    end else if (ack_req) begin
      next_wd_req_pend = 1'b0;
    end
  end

  // line requests stay until acknowledged; a new hit wins over the acknowledge
  always @* begin
    next_ei_pend = ei_pend & {`WDEI_LINES{~ack_req}};
    next_ei_pend = next_ei_pend | ei_hit;
  end

  // direction byte comes from a transfer on the interrupt channel
  always @* begin
    next_edge_dir = edge_dir;
    if (dir_wr) begin
      next_edge_dir = out_data;
    end
  end

  // watchdog timing registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt <= {`WDEI_CW{1'b0}};
      armed  <= 1'b0;
    end else begin
      wd_cnt <= next_wd_cnt;
      armed  <= next_armed;
    end
  end

  // alarm and relay move on the same edge, so the relay never lags the alarm
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm        <= 1'b0;
      relay_closed <= 1'b1;
    end else begin
      alarm        <= next_alarm;
      relay_closed <= ~next_alarm;
    end
  end

  // watchdog tick pending
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_req_pend <= 1'b0;
    end else begin
      wd_req_pend <= next_wd_req_pend;
    end
  end

  // line pending bits and the shared request line
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ei_pend <= {`WDEI_LINES{1'b0}};
      request <= 1'b0;
    end else begin
      ei_pend <= next_ei_pend;
      request <= next_wd_req_pend | (|next_ei_pend);
    end
  end

  // edge direction register; all lines start on rising edges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_dir <= {`WDEI_LINES{1'b1}};
    end else begin
      edge_dir <= next_edge_dir;
    end
  end
endmodule // wdei_unit

/* testbench/tb_wdei_unit.sv */
// self-checking bench for the unit
`timescale 1ns/1ns
module tb_wdei_unit;
  logic       clk = 0, rst_b = 0, blank_long = 0, wd_mode = 1, alarm_clear = 0;
  logic       wd_fitted = 1, ei_fitted = 1;
  logic [7:0] base_chan = 8'h20, line_in = 8'h00;
  wire        out_strobe, ack_req, request, wd_req_pend, alarm, relay_closed;
  wire  [7:0] out_chan, out_data, ei_pend, edge_dir;
  int         num_errors = 0, compares = 0;
  // direction, line before, line after, expected pending
  logic [31:0] rows [4] = '{32'hFF000F0F, 32'h000F000F, 32'h0000F000, 32'hAA00FFAA};
  initial forever #5 clk = ~clk;
  wdei_cpu wdei_cpu_i (.*);
  wdei_unit #(.WIN_LO(28'h5A), .WIN_HI(28'h6E), .PERIOD(28'h64), .OPEN_W(28'hA),
    .BLANK_L(22'h20), .BLANK_S(22'h4)) wdei_unit_i (.*);
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task kick;
    wdei_cpu_i.xfer(8'h20, 8'h00);
    cyc(1);
  endtask
  initial begin
    cyc(5);
    rst_b = 1;
    foreach (rows[i]) begin
      wdei_cpu_i.xfer(8'h21, rows[i][31:24]);
      line_in = rows[i][23:16];
      cyc(40);
      wdei_cpu_i.ack;
      line_in = rows[i][15:8];
      cyc(3);
      chk(edge_dir, rows[i][31:24], "dir");
      chk(ei_pend, rows[i][7:0], "pend");
    end
    blank_long = 1;
    wdei_cpu_i.xfer(8'h21, 8'hFF);
    line_in = 8'h00;
    cyc(40);
    wdei_cpu_i.ack;
    for (int k = 0; k < 4; k++) begin
      line_in = k[0] ? 8'h00 : 8'h01;
      cyc(k == 0 ? 3 : k == 1 ? 2 : k == 2 ? 32 : 3);
      if (k == 0) wdei_cpu_i.ack;
      if (k == 1) chk(ei_pend, 8'h00, "bounce");
    end
    line_in = 8'h01;
    cyc(3);
    chk(ei_pend, 8'h01, "after blank");
    wd_mode = 0;
    rst_b = 0;
    cyc(5);
    chk({request, alarm, relay_closed, edge_dir}, 11'h1FF, "reset");
    rst_b = 1;
    kick;
    cyc(97);
    kick;
    chk(alarm, 8'h00, "paced kicks");
    cyc(47);
    kick;
    chk({alarm, relay_closed}, 8'h02, "early kick");
    alarm_clear = 1;
    cyc(1);
    alarm_clear = 0;
    chk(alarm, 8'h00, "clear");
    cyc(120);
    chk(alarm, 8'h01, "no kick");
    wd_mode = 1;
    alarm_clear = 1;
    cyc(1);
    alarm_clear = 0;
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 150 && wd_req_pend !== 1'b1; n++) cyc(1);
      chk(request, 8'h01, "tick");
      wdei_cpu_i.ack;
      cyc(k * 40 + 1);
      kick;
      chk(alarm, k[7:0], "periodic kick");
    end
    wd_fitted = 0;
    base_chan = 8'h33;
    wdei_cpu_i.xfer(8'h33, 8'h5A);
    cyc(1);
    chk(edge_dir, 8'h5A, "lone interrupt chan");
    {wd_fitted, ei_fitted, base_chan} = {2'b10, 8'h20};
    wdei_cpu_i.xfer(8'h21, 8'h0F);
    cyc(1);
    chk(edge_dir, 8'h5A, "unfitted interrupt chan");
    results;
  end
  initial begin
    #50000;
    num_errors++;
    results;
  end
endmodule // tb_wdei_unit

/* testbench/wdei_chk.sv */
// assertion checker for the unit ports
`timescale 1ns/1ns
module wdei_chk (
  input wire       clk, rst_b, wd_mode, ack_req, alarm_clear,
  input wire       request, wd_req_pend, alarm, relay_closed,
  input wire [7:0] line_in, ei_pend, edge_dir
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_relay_open: assert property (relay_closed != alarm) else $error("relay");
  a_req_shared: assert property (request == (wd_req_pend || |ei_pend)) else $error("req");
  a_alarm_held: assert property (alarm && !alarm_clear |=> alarm) else $error("alarm");
  a_pend_held: assert property (!ack_req |=> (ei_pend & $past(ei_pend)) == $past(ei_pend))
    else $error("pend");
  a_edge_cause: assert property ($rose(ei_pend[0]) |-> $past(line_in[0], 2) !=
    $past(line_in[0], 3)) else $error("edge");
  a_dir_apply: assert property ($rose(ei_pend[0]) |-> $past(line_in[0], 2) == $past(edge_dir[0], 2))
    else $error("dir");
  a_tick_mode: assert property ($rose(wd_req_pend) |-> $past(wd_mode)) else $error("tick");
  a_ack_clear: assert property (ack_req && !wd_mode |=> !wd_req_pend) else $error("ack");
  c_alarm: cover property ($rose(alarm));
  c_tick: cover property ($rose(wd_req_pend));
  c_edge: cover property ($rose(ei_pend[0]));
endmodule // wdei_chk
bind wdei_unit wdei_chk wdei_chk_i (.*);

/* testbench/wdei_cpu.sv */
// processor model: output transfers and acknowledges
`timescale 1ns/1ns
module wdei_cpu (
  input  wire       clk,
  output reg        out_strobe,
  output reg        ack_req,
  output reg  [7:0] out_chan,
  output reg  [7:0] out_data
);
  initial {out_strobe, ack_req, out_chan, out_data} = 18'h0;
  // caller times each kick, inside or outside the window; direction byte on odd channel
  task xfer(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk) #1 {out_strobe, out_chan, out_data} = {1'b1, c, d};
    @(posedge clk) #1 {out_strobe, out_chan, out_data} = {1'b0, ~c, ~d};
  endtask
  task ack;
    @(posedge clk) #1 ack_req = 1'b1;
    @(posedge clk) #1 ack_req = 1'b0;
  endtask
endmodule // wdei_cpu
